// ### design/serial_link_param_and_test_ctrl.sv
// Link parameter registers, lane checksums and lane/converter test source selection
`timescale 1ns/100ps
`include "serial_link_map.svh"

module serial_link_param_and_test_ctrl #(
  // Link identifier folded into the checksum; value is arbitrary
  parameter logic [7:0] LINK_ID = `SL_RST_DEVID
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port from the serial control interface
  input wire logic [`SL_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Datapath sources
  input wire logic [1:0][7:0] frame_data_i,
  input wire logic [1:0][9:0] encoder_data_i,
  input wire serial_link_pkg::sample_t [1:0] sample_i,
  // Lane side results
  output logic [1:0][7:0] scr_data_o,
  output logic [1:0][9:0] lane_data_o,
  output logic [1:0] lane_neg_edge_o,
  output logic [1:0] lane_powerdown_o,
  // Converter side results
  output serial_link_pkg::sample_t [1:0] conv_data_o,
  output logic [1:0] converter_powerdown_o,
  // Link parameters for the framer
  output serial_link_pkg::link_params_t link_params_o,
  output logic scr_en_o
);

  // Parameter registers, one struct for the whole link
  serial_link_pkg::link_params_t params_reg;
  // Lane identifiers
  logic [4:0] lane_id_reg [2];
  // Checksums, index 0 is the first lane
  logic [7:0] checksum_reg [2];
  // Per-lane and per-converter control
  serial_link_pkg::lane_ctrl_t lane_reg [2];
  serial_link_pkg::conv_ctrl_t conv_reg [2];
  // Pseudo_random_select and generator state
  logic [1:0] pseudo_random_select;
  logic [30:0] lfsr_reg;
  logic [30:0] lfsr_next;
  // Shared toggle for toggle mode
  logic toggle_reg;
  // Read data holding register
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Write decode, one strobe per register
  wire logic wr_prbs = reg_wr_i && (reg_addr_i == `SL_ADDR_PRBS);
  wire logic wr_bank = reg_wr_i && (reg_addr_i == `SL_ADDR_BANK);
  wire logic wr_scr_l = reg_wr_i && (reg_addr_i == `SL_ADDR_SCR_L);
  wire logic wr_f = reg_wr_i && (reg_addr_i == `SL_ADDR_F);
  wire logic wr_k = reg_wr_i && (reg_addr_i == `SL_ADDR_K);
  wire logic wr_m = reg_wr_i && (reg_addr_i == `SL_ADDR_M);
  wire logic wr_cs_n = reg_wr_i && (reg_addr_i == `SL_ADDR_CS_N);
  wire logic wr_np = reg_wr_i && (reg_addr_i == `SL_ADDR_NP);
  wire logic wr_s = reg_wr_i && (reg_addr_i == `SL_ADDR_S);
  wire logic wr_hd_cf = reg_wr_i && (reg_addr_i == `SL_ADDR_HD_CF);
  wire logic [1:0] wr_lid;
  wire logic [1:0] wr_lane;
  wire logic [1:0] wr_conv;
  assign wr_lid[0] = reg_wr_i && (reg_addr_i == `SL_ADDR_LID0);
  assign wr_lid[1] = reg_wr_i && (reg_addr_i == `SL_ADDR_LID1);
  assign wr_lane[0] = reg_wr_i && (reg_addr_i == `SL_ADDR_LANE0);
  assign wr_lane[1] = reg_wr_i && (reg_addr_i == `SL_ADDR_LANE1);
  assign wr_conv[0] = reg_wr_i && (reg_addr_i == `SL_ADDR_CONV0);
  assign wr_conv[1] = reg_wr_i && (reg_addr_i == `SL_ADDR_CONV1);

  // Bank id, only the low nibble is stored
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.bank_id <= `SL_RST_BANK;
    end else if (wr_bank) begin
      params_reg.bank_id <= reg_wdata_i[3:0];
    end
  end

  // Scrambling enable and lane count share a register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.scr_en <= 1'b0;
      params_reg.lanes_m1 <= 1'b0;
    end else if (wr_scr_l) begin
      params_reg.scr_en <= reg_wdata_i[`SL_BIT_SCR];
      params_reg.lanes_m1 <= reg_wdata_i[0];
    end
  end

  // Octets per frame
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.octets_m1 <= 3'h0;
    end else if (wr_f) begin
      params_reg.octets_m1 <= reg_wdata_i[2:0];
    end
  end

  // Frames per multiframe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.frames_m1 <= 5'h00;
    end else if (wr_k) begin
      params_reg.frames_m1 <= reg_wdata_i[4:0];
    end
  end

  // Converter count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.convs_m1 <= 1'b0;
    end else if (wr_m) begin
      params_reg.convs_m1 <= reg_wdata_i[0];
    end
  end

  // Control bits per sample and resolution share a register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.ctrl_bits_m1 <= 1'b0;
      params_reg.resolution <= 4'h0;
    end else if (wr_cs_n) begin
      params_reg.ctrl_bits_m1 <= reg_wdata_i[`SL_BIT_CS];
      params_reg.resolution <= reg_wdata_i[3:0];
    end
  end

  // Total bits per sample
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.total_bits_m1 <= 5'h00;
    end else if (wr_np) begin
      params_reg.total_bits_m1 <= reg_wdata_i[4:0];
    end
  end

  // Samples per converter per frame
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.samples <= 1'b0;
    end else if (wr_s) begin
      params_reg.samples <= reg_wdata_i[0];
    end
  end

  // High density flag and control words
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      params_reg.high_density <= 1'b0;
      params_reg.ctrl_words <= 2'h0;
    end else if (wr_hd_cf) begin
      params_reg.high_density <= reg_wdata_i[`SL_BIT_HD];
      params_reg.ctrl_words <= reg_wdata_i[1:0];
    end
  end

  // Pseudo_random_select selector
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pseudo_random_select <= 2'h0;
    end else if (wr_prbs) begin
      pseudo_random_select <= reg_wdata_i[1:0];
    end
  end

  // Checksum part common to both lanes; each field counts at its own value
  wire logic [7:0] common_sum = LINK_ID
    + 8'(params_reg.bank_id)
    + 8'(params_reg.scr_en)
    + 8'(params_reg.lanes_m1)
    + 8'(params_reg.octets_m1)
    + 8'(params_reg.frames_m1)
    + 8'(params_reg.convs_m1)
    + 8'(params_reg.resolution)
    + 8'(params_reg.ctrl_bits_m1)
    + 8'(params_reg.total_bits_m1)
    + 8'(params_reg.samples)
    + 8'(params_reg.high_density)
    + 8'(params_reg.ctrl_words);

  // Reset values of the lane identifiers
  wire logic [4:0] lid_rst [2] = '{`SL_RST_LID0, `SL_RST_LID1};

  // PRBS taps by type; codes 00 and 01 both give the short sequence
  logic fb_raw;
  always_comb begin
    case (pseudo_random_select)
      2'b10: fb_raw = lfsr_reg[22] ^ lfsr_reg[17];
      2'b11: fb_raw = lfsr_reg[30] ^ lfsr_reg[27];
      default: fb_raw = lfsr_reg[6] ^ lfsr_reg[5];
    endcase
  end

  // Active length of the generator; a type change could leave it all zero
  wire logic [30:0] prbs_mask = (pseudo_random_select == 2'b10) ? `SL_MASK_PRBS23 :
    (pseudo_random_select == 2'b11) ? `SL_MASK_PRBS31 : `SL_MASK_PRBS7;
  wire logic lfsr_zero = ((lfsr_reg & prbs_mask) == 31'h00000000);
  assign lfsr_next = {lfsr_reg[29:0], fb_raw | lfsr_zero};

  // Generator and toggle run every cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lfsr_reg <= `SL_LFSR_SEED;
      toggle_reg <= 1'b0;
    end else begin
      lfsr_reg <= lfsr_next;
      toggle_reg <= ~toggle_reg;
    end
  end

  // Per-lane logic
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [9:0] mode_word;
    logic [9:0] lane_next;
    logic [7:0] scr_next;

    // Lane identifier
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        lane_id_reg[i] <= lid_rst[i];
      end else if (wr_lid[i]) begin
        lane_id_reg[i] <= reg_wdata_i[4:0];
      end
    end

    // Checksum is recomputed every cycle, so it trails a write by one edge
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        checksum_reg[i] <= 8'h00;
      end else begin
        checksum_reg[i] <= common_sum + 8'(lane_id_reg[i]);
      end
    end

    // Lane control register
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        lane_reg[i] <= '0;
      end else if (wr_lane[i]) begin
        lane_reg[i] <= {reg_wdata_i[6:4], reg_wdata_i[2:0]};
      end
    end

    // Scrambler source
    assign scr_next = lane_reg[i].scr_src ? lfsr_reg[7:0] : frame_data_i[i];

    // Lane output source
    always_comb begin
      case (lane_reg[i].mode)
        serial_link_pkg::LANE_NORMAL: mode_word = encoder_data_i[i];
        serial_link_pkg::LANE_CONST: mode_word = 10'h000;
        serial_link_pkg::LANE_TOGGLE: mode_word = {9'h000, toggle_reg};
        serial_link_pkg::LANE_PRBS: mode_word = lfsr_reg[9:0];
        default: mode_word = 10'h000;
      endcase
    end

    // Polarity, then a quiet lane while powered down
    assign lane_next = lane_reg[i].lane_powerdown ? 10'h000 :
      (lane_reg[i].lane_invert ? ~mode_word : mode_word);

    // Registered lane outputs
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        scr_data_o[i] <= 8'h00;
        lane_data_o[i] <= 10'h000;
      end else begin
        scr_data_o[i] <= scr_next;
        lane_data_o[i] <= lane_next;
      end
    end

    // Edge and power-down flags come straight from the control flops
    assign lane_neg_edge_o[i] = lane_reg[i].neg_edge;
    assign lane_powerdown_o[i] = lane_reg[i].lane_powerdown;
  end

  // Per-converter logic
  for (genvar j = 0; j < 2; j++) begin : g_conv
    serial_link_pkg::sample_t conv_next;

    // Converter control register
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        conv_reg[j] <= '0;
      end else if (wr_conv[j]) begin
        conv_reg[j] <= {reg_wdata_i[5:4], reg_wdata_i[`SL_BIT_PD]};
      end
    end

    // Feed selection; the unused code gives zero rather than stale data
    always_comb begin
      case (conv_reg[j].mode)
        serial_link_pkg::CONV_LIVE: conv_next = sample_i[j];
        serial_link_pkg::CONV_CONST: conv_next = `SL_CONST_SAMPLE;
        serial_link_pkg::CONV_PRBS: conv_next = lfsr_reg[14:0];
        default: conv_next = 15'h0000;
      endcase
    end

    // Powered-down converter feeds zeros
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        conv_data_o[j] <= 15'h0000;
      end else begin
        conv_data_o[j] <= conv_reg[j].converter_powerdown ? 15'h0000 : conv_next;
      end
    end

    assign converter_powerdown_o[j] = conv_reg[j].converter_powerdown;
  end

  // Read mux; unused bits and unmapped offsets read zero
  always_comb begin
    case (reg_addr_i)
      `SL_ADDR_PRBS: rdata_next = {6'h00, pseudo_random_select};
      `SL_ADDR_DEVID: rdata_next = LINK_ID;
      `SL_ADDR_BANK: rdata_next = {4'h0, params_reg.bank_id};
      `SL_ADDR_SCR_L: rdata_next = {params_reg.scr_en, 6'h00, params_reg.lanes_m1};
      `SL_ADDR_F: rdata_next = {5'h00, params_reg.octets_m1};
      `SL_ADDR_K: rdata_next = {3'h0, params_reg.frames_m1};
      `SL_ADDR_M: rdata_next = {7'h00, params_reg.convs_m1};
      `SL_ADDR_CS_N: rdata_next = {1'b0, params_reg.ctrl_bits_m1, 2'h0,
        params_reg.resolution};
      `SL_ADDR_NP: rdata_next = {3'h0, params_reg.total_bits_m1};
      `SL_ADDR_S: rdata_next = {7'h00, params_reg.samples};
      `SL_ADDR_HD_CF: rdata_next = {params_reg.high_density, 5'h00,
        params_reg.ctrl_words};
      `SL_ADDR_LID0: rdata_next = {3'h0, lane_id_reg[0]};
      `SL_ADDR_LID1: rdata_next = {3'h0, lane_id_reg[1]};
      `SL_ADDR_CHK0: rdata_next = checksum_reg[0];
      `SL_ADDR_CHK1: rdata_next = checksum_reg[1];
      `SL_ADDR_LANE0: rdata_next = {1'b0, lane_reg[0][5:3], 1'b0, lane_reg[0][2:0]};
      `SL_ADDR_LANE1: rdata_next = {1'b0, lane_reg[1][5:3], 1'b0, lane_reg[1][2:0]};
      `SL_ADDR_CONV0: rdata_next = {2'h0, conv_reg[0][2:1], 3'h0, conv_reg[0][0]};
      `SL_ADDR_CONV1: rdata_next = {2'h0, conv_reg[1][2:1], 3'h0, conv_reg[1][0]};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and held until the next one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // Register-sourced outputs
  assign reg_rdata_o = rdata_reg;
  assign link_params_o = params_reg;
  assign scr_en_o = params_reg.scr_en;

endmodule : serial_link_param_and_test_ctrl

// ### pkg/serial_link_map.svh
// Register offsets, field positions, reset values and fixed values of the link register bank
`ifndef SERIAL_LINK_MAP_SVH
`define SERIAL_LINK_MAP_SVH
`define SL_ADDR_W 13
`define SL_ADDR_PRBS 13'h80b
`define SL_ADDR_DEVID 13'h820
`define SL_ADDR_BANK 13'h821
`define SL_ADDR_SCR_L 13'h822
`define SL_ADDR_F 13'h823
`define SL_ADDR_K 13'h824
`define SL_ADDR_M 13'h825
`define SL_ADDR_CS_N 13'h826
`define SL_ADDR_NP 13'h827
`define SL_ADDR_S 13'h828
`define SL_ADDR_HD_CF 13'h829
`define SL_ADDR_LID0 13'h82c
`define SL_ADDR_LID1 13'h82d
`define SL_ADDR_CHK1 13'h84c
`define SL_ADDR_CHK0 13'h84d
`define SL_ADDR_LANE0 13'h870
`define SL_ADDR_LANE1 13'h871
`define SL_ADDR_CONV0 13'h890
`define SL_ADDR_CONV1 13'h891
`define SL_BIT_SCR 7
`define SL_BIT_HD 7
`define SL_BIT_CS 6
`define SL_BIT_SCR_SRC 6
`define SL_BIT_INVERT 2
`define SL_BIT_NEG_EDGE 1
`define SL_BIT_PD 0
`define SL_RST_BANK 4'ha
`define SL_RST_LID0 5'h1b
`define SL_RST_LID1 5'h1c
`define SL_RST_DEVID 8'h5a
`define SL_CONST_SAMPLE 15'h66ea
`define SL_LFSR_SEED 31'h7fffffff
`define SL_MASK_PRBS7 31'h0000007f
`define SL_MASK_PRBS23 31'h007fffff
`define SL_MASK_PRBS31 31'h7fffffff
`endif

// ### pkg/serial_link_pkg.sv
// Types shared by the link register bank and its users
package serial_link_pkg;
  typedef enum logic [1:0] {
    LANE_NORMAL = 2'b00,
    LANE_CONST = 2'b01,
    LANE_TOGGLE = 2'b10,
    LANE_PRBS = 2'b11
  } lane_mode_t;
  typedef enum logic [1:0] {
    CONV_LIVE = 2'b00,
    CONV_UNUSED = 2'b01,
    CONV_CONST = 2'b10,
    CONV_PRBS = 2'b11
  } conv_mode_t;
  typedef struct packed {
    logic scr_src;
    lane_mode_t mode;
    logic lane_invert;
    logic neg_edge;
    logic lane_powerdown;
  } lane_ctrl_t;
  typedef struct packed {
    conv_mode_t mode;
    logic converter_powerdown;
  } conv_ctrl_t;
  typedef struct packed {
    logic overrange_flag;
    logic [13:0] data;
  } sample_t;
  typedef struct packed {
    logic [3:0] bank_id;
    logic scr_en;
    logic lanes_m1;
    logic [2:0] octets_m1;
    logic [4:0] frames_m1;
    logic convs_m1;
    logic ctrl_bits_m1;
    logic [3:0] resolution;
    logic [4:0] total_bits_m1;
    logic samples;
    logic high_density;
    logic [1:0] ctrl_words;
  } link_params_t;
endpackage : serial_link_pkg

// ### testbench/link_rx_model.sv
// Receiver-side model that takes in each lane word as it arrives
`timescale 1ns/100ps
module link_rx_model (
  // Clock
  input wire logic clk_i,
  // Lane words from the transmitter
  input wire logic [1:0][9:0] lane_data_i,
  // Word taken on the previous edge
  output logic [1:0][9:0] prev_word_o
);
  // Latch every word on the rising edge, as a deserializer would
  always_ff @(posedge clk_i) begin
    prev_word_o <= lane_data_i;
  end
endmodule : link_rx_model

// ### testbench/serial_link_param_and_test_ctrl_chk.sv
// Concurrent checks on the link register bank ports
`timescale 1ns/100ps
`include "serial_link_map.svh"
module serial_link_param_and_test_ctrl_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [`SL_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  // Datapath
  input wire serial_link_pkg::sample_t [1:0] sample_i,
  input wire logic [1:0][9:0] lane_data_o,
  input wire logic [1:0] lane_neg_edge_o,
  input wire logic [1:0] lane_powerdown_o,
  input wire serial_link_pkg::sample_t [1:0] conv_data_o,
  input wire logic [1:0] converter_powerdown_o,
  input wire serial_link_pkg::link_params_t link_params_o,
  input wire logic scr_en_o
);
  logic [7:0] lane0_q; // Shadow of the first lane control
  logic [7:0] conv0_q; // Shadow of the first converter control
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Track control writes; unused bits are dropped so compares match the register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lane0_q <= 8'h00;
      conv0_q <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == `SL_ADDR_LANE0) begin
      lane0_q <= reg_wdata_i & 8'h77;
    end else if (reg_wr_i && reg_addr_i == `SL_ADDR_CONV0) begin
      conv0_q <= reg_wdata_i & 8'h31;
    end
  end
  chk_reset_bank: assert property ($past(reset_i) |->
    link_params_o.bank_id == 4'ha && !scr_en_o)
    else $error("bank id or scramble wrong after reset");
  chk_scr_write: assert property (reg_wr_i && reg_addr_i == `SL_ADDR_SCR_L |=>
    scr_en_o == $past(reg_wdata_i[7]) && link_params_o.lanes_m1 == $past(reg_wdata_i[0]))
    else $error("scramble or lane count not written");
  chk_octet_write: assert property (reg_wr_i && reg_addr_i == `SL_ADDR_F |=>
    link_params_o.octets_m1 == $past(reg_wdata_i[2:0])) else $error("octet count not written");
  chk_lane_powerdown_write: assert property (reg_wr_i && reg_addr_i == `SL_ADDR_LANE0 |=>
    lane_powerdown_o[0] == $past(reg_wdata_i[0])) else $error("lane power-down not written");
  chk_edge_write: assert property (reg_wr_i && reg_addr_i == `SL_ADDR_LANE1 |=>
    lane_neg_edge_o[1] == $past(reg_wdata_i[1])) else $error("serializer edge not written");
  chk_conv_pd_write: assert property (reg_wr_i && reg_addr_i == `SL_ADDR_CONV1 |=>
    converter_powerdown_o[1] == $past(reg_wdata_i[0])) else $error("converter power-down lost");
  // Three settled cycles are needed because the output lags the mode by one
  chk_lane_toggle: assert property (lane0_q == 8'h20 && $past(lane0_q) == 8'h20
    && $past(lane0_q, 2) == 8'h20 |-> lane_data_o[0] inside {10'h000, 10'h001}
    && lane_data_o[0] != $past(lane_data_o[0])) else $error("toggle mode not toggling");
  chk_pd_silent: assert property (lane_powerdown_o[0] && $past(lane_powerdown_o[0]) |->
    lane_data_o[0] == 10'h000) else $error("powered-down lane still drives");
  chk_conv_const: assert property (conv0_q == 8'h20 && $past(conv0_q) == 8'h20 |->
    conv_data_o[0] == `SL_CONST_SAMPLE) else $error("constant sample wrong");
  chk_conv_live: assert property (conv0_q == 8'h00 && $past(conv0_q) == 8'h00
    && !$past(reset_i) |-> conv_data_o[0] == $past(sample_i[0])) else $error("live sample lost");
endmodule : serial_link_param_and_test_ctrl_chk
bind serial_link_param_and_test_ctrl serial_link_param_and_test_ctrl_chk
  serial_link_param_and_test_ctrl_chk_inst (.clk_i(clk_i), .reset_i(reset_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .sample_i(sample_i), .lane_data_o(lane_data_o), .lane_neg_edge_o(lane_neg_edge_o),
  .lane_powerdown_o(lane_powerdown_o), .conv_data_o(conv_data_o),
  .converter_powerdown_o(converter_powerdown_o), .link_params_o(link_params_o),
  .scr_en_o(scr_en_o));

// ### testbench/tb.sv
// Self-checking bench for the link register bank
`timescale 1ns/100ps
`include "serial_link_map.svh"
`define TB_CMP(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
  $display("FAIL %s exp %h got %h", nm, ex, got); end end
module tb;
  localparam logic [7:0] LINK_ID_T = 8'h33; // Link id, value is arbitrary
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [12:0] reg_addr_i = 13'h0000;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  // Lanes differ, and neither byte can match a PRBS byte (its low 7 bits are never all zero)
  logic [1:0][7:0] frame_data_i = {8'h00, 8'h80};
  logic [1:0][9:0] encoder_data_i = {10'h15a, 10'h2a5};
  serial_link_pkg::sample_t [1:0] sample_i = {15'h0c0c, 15'h1234};
  logic [1:0][7:0] scr_data_o;
  logic [1:0][9:0] lane_data_o;
  logic [1:0] lane_neg_edge_o;
  logic [1:0] lane_powerdown_o;
  serial_link_pkg::sample_t [1:0] conv_data_o;
  logic [1:0] converter_powerdown_o;
  serial_link_pkg::link_params_t link_params_o;
  logic scr_en_o;
  logic [1:0][9:0] prev_word; // Word the receiver took one edge earlier
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] sh [int]; // Expected register contents by offset
  // Register table: offset, writable bits, reset value
  logic [12:0] ra [16] = '{13'h821, 13'h822, 13'h823, 13'h824, 13'h825, 13'h826, 13'h827,
    13'h828, 13'h829, 13'h82c, 13'h82d, 13'h870, 13'h871, 13'h890, 13'h891, 13'h80b};
  logic [7:0] rm [16] = '{8'h0f, 8'h81, 8'h07, 8'h1f, 8'h01, 8'h4f, 8'h1f, 8'h01, 8'h83,
    8'h1f, 8'h1f, 8'h77, 8'h77, 8'h31, 8'h31, 8'h03};
  logic [7:0] rr [16] = '{0: 8'h0a, 9: 8'h1b, 10: 8'h1c, default: 8'h00};
  logic [7:0] pat [3] = '{8'hff, 8'h5a, 8'h00}; // Write patterns
  logic [12:0] ro [3] = '{13'h820, 13'h84c, 13'h84d}; // Read-only offsets
  always #5 clk_i = ~clk_i;
  serial_link_param_and_test_ctrl #(.LINK_ID(LINK_ID_T)) serial_link_param_and_test_ctrl_inst (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .frame_data_i(frame_data_i), .encoder_data_i(encoder_data_i), .sample_i(sample_i),
    .scr_data_o(scr_data_o), .lane_data_o(lane_data_o), .lane_neg_edge_o(lane_neg_edge_o),
    .lane_powerdown_o(lane_powerdown_o), .conv_data_o(conv_data_o),
    .converter_powerdown_o(converter_powerdown_o), .link_params_o(link_params_o),
    .scr_en_o(scr_en_o));
  link_rx_model link_rx_model_inst (.clk_i(clk_i), .lane_data_i(lane_data_o),
    .prev_word_o(prev_word));
  // Wait edges, then step just past the edge where inputs change
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // One write strobe, then an idle edge so the checksum has settled on return
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask : wr
  // Read data is loaded on the strobe edge and held until the next read
  task automatic rd(input logic [12:0] a, input logic [7:0] ex, input string nm);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    `TB_CMP(nm, ex, reg_rdata_o)
    cyc(1);
  endtask : rd
  // Sum of the link fields, mod 256 by the 8-bit result
  function automatic logic [7:0] cks(input logic [7:0] lid);
    cks = LINK_ID_T + sh[13'h821] + sh[13'h822][7] + sh[13'h822][0] + sh[13'h823]
      + sh[13'h824] + sh[13'h825] + sh[13'h826][6] + sh[13'h826][3:0] + sh[13'h827]
      + sh[13'h828] + sh[13'h829][7] + sh[13'h829][1:0] + lid;
  endfunction : cks
  // Checksums, the fixed id and an unmapped offset
  task automatic check_fixed;
    rd(13'h84d, cks(sh[13'h82c]), "first checksum");
    rd(13'h84c, cks(sh[13'h82d]), "second checksum");
    rd(13'h820, LINK_ID_T, "device id");
    rd(13'h830, 8'h00, "unmapped");
  endtask : check_fixed
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Whole run is about a thousand cycles; this cuts a hang short
  initial begin : watchdog
    #100000;
    fails++;
    stop_test();
  end
  initial begin : main
    serial_link_pkg::link_params_t pv; // Expected link parameter outputs
    logic [9:0] w0;
    logic [9:0] iv;
    serial_link_pkg::sample_t sv;
    cyc(6);
    reset_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(ra[i], rr[i], "reset value");
      sh[ra[i]] = rr[i];
    end
    check_fixed();
    // Unused bits must drop and read-only offsets must ignore writes
    foreach (pat[p]) begin
      for (int i = 0; i < 16; i++) begin
        wr(ra[i], pat[p]);
        sh[ra[i]] = pat[p] & rm[i];
      end
      foreach (ro[j]) wr(ro[j], pat[p]);
      for (int i = 0; i < 16; i++) begin
        rd(ra[i], sh[ra[i]], "readback");
      end
      check_fixed();
      // The framer sees the same field values that read back
      pv = {sh[13'h821][3:0], sh[13'h822][7], sh[13'h822][0], sh[13'h823][2:0],
        sh[13'h824][4:0], sh[13'h825][0], sh[13'h826][6], sh[13'h826][3:0], sh[13'h827][4:0],
        sh[13'h828][0], sh[13'h829][7], sh[13'h829][1:0]};
      `TB_CMP("link params", pv, link_params_o)
    end
    // Every lane mode, plain and inverted, on both lanes
    for (int l = 0; l < 2; l++) begin
      for (int m = 0; m < 8; m++) begin
        iv = {10{m[2]}};
        wr(13'(13'h870 + l), {2'b00, m[1:0], 1'b0, m[2], 2'b00});
        cyc(2);
        `TB_CMP("scrambler feed", frame_data_i[l], scr_data_o[l])
        case (m[1:0])
          2'b00: `TB_CMP("encoder", encoder_data_i[l] ^ iv, lane_data_o[l])
          2'b01: `TB_CMP("constant", iv, lane_data_o[l])
          2'b10: begin
            `TB_CMP("toggle step", 10'h001, lane_data_o[l] ^ prev_word[l])
            `TB_CMP("toggle level", iv & 10'h3fe, lane_data_o[l] & 10'h3fe)
          end
          default: `TB_CMP("lane prbs moves", 1'b0, lane_data_o[l] == prev_word[l])
        endcase
      end
      wr(13'(13'h870 + l), 8'h40);
      `TB_CMP("scrambler prbs", 1'b0, scr_data_o[l] == frame_data_i[l])
      wr(13'(13'h870 + l), 8'h03);
      cyc(1);
      `TB_CMP("neg edge", 1'b1, lane_neg_edge_o[l])
      `TB_CMP("lane_powerdown", 1'b1, lane_powerdown_o[l])
      `TB_CMP("lane_powerdown data", 10'h000, lane_data_o[l])
      wr(13'(13'h870 + l), 8'h00);
      `TB_CMP("pos edge", 1'b0, lane_neg_edge_o[l])
    end
    // Every converter feed, then power-down
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(13'(13'h890 + c), 8'(m << 4));
        cyc(1);
        sv = conv_data_o[c];
        cyc(1);
        case (m)
          0: `TB_CMP("live", sample_i[c], conv_data_o[c])
          1: `TB_CMP("unused code", 15'h0000, conv_data_o[c])
          2: `TB_CMP("const sample", 15'h66ea, conv_data_o[c])
          default: `TB_CMP("conv prbs moves", 1'b0, conv_data_o[c] == sv)
        endcase
      end
      wr(13'(13'h890 + c), 8'h01);
      cyc(1);
      `TB_CMP("conv pd", 1'b1, converter_powerdown_o[c])
      `TB_CMP("conv pd data", 15'h0000, conv_data_o[c])
      wr(13'(13'h890 + c), 8'h00);
    end
    // A mid-run reset must bring every register back to its reset value
    wr(13'h821, 8'h05);
    reset_i = 1'b1;
    cyc(2);
    reset_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(ra[i], rr[i], "reset again");
    end
    // Only the 7-stage sequence repeats after 127 steps
    wr(13'h870, 8'h30);
    for (int t = 0; t < 4; t++) begin
      wr(13'h80b, 8'(t));
      cyc(2);
      w0 = lane_data_o[0];
      cyc(127);
      `TB_CMP("prbs period", t < 2, lane_data_o[0] == w0)
    end
    stop_test();
  end
endmodule : tb
